// ===== logic/dscs_pkg.sv
package dscs_pkg;
    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [11:0] DSCS_CKCTL_IDX    = 12'h08f;            // printed index
    localparam logic [11:0] DSCS_CKCTL_ADDR   = 12'(DSCS_CKCTL_IDX * 4);
    localparam logic [7:0]  DSCS_CKCTL_RESET  = 8'h00;
    localparam int          DSCS_CPU_BIT      = 0;                  // cpu_double_speed
    localparam int          DSCS_SEL_LSB      = 1;                  // timer0 select
    localparam int          DSCS_NUM_PERIPH   = 7;                  // timer0..can
    localparam int          DSCS_REG_W        = 8;

    // ************************************************************
    // cycle figures
    // ************************************************************
    localparam int          DSCS_PHASES_PER_CYCLE = 6;              // phases per cycle
    localparam int          DSCS_OSC_STD          = 12;             // osc periods, standard
    localparam int          DSCS_OSC_FAST         = 6;              // osc periods, double
endpackage

// ===== logic/dscs_cycle_counter.sv
`timescale 1ns/100ps
module dscs_cycle_counter
    import dscs_pkg::*;
#(
    parameter int PHASES = DSCS_PHASES_PER_CYCLE
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic phase_en,
    output logic      cycle_en
);
    localparam int CW = $clog2(PHASES);
    localparam logic [CW-1:0] LAST = CW'(PHASES - 1);

    logic [CW-1:0] cnt_q;
    logic          cycle_q;

    // count phase pulses, one cycle pulse after the last phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= '0;
            cycle_q <= 1'b0;
        end else if (phase_en && cnt_q == LAST) begin
            cnt_q   <= '0;
            cycle_q <= 1'b1;
        end else begin
            if (phase_en) begin
                cnt_q <= cnt_q + 1'b1;
            end
            cycle_q <= 1'b0;
        end
    end

    assign cycle_en = cycle_q;
endmodule // dscs_cycle_counter

// ===== logic/dscs_clock_select.sv
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/100ps
module dscs_clock_select
    import dscs_pkg::*;
#(
    parameter int NP = DSCS_NUM_PERIPH
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          boot_double_speed_fuse,
    output logic               standard_speed_mode,
    output logic               core_phase_en,
    output logic               machine_cycle_en,
    output logic      [NP-1:0] periph_phase_en,
    output logic      [NP-1:0] periph_cycle_en
);
    // ************************************************************
    // register file
    // ************************************************************
    logic [DSCS_REG_W-1:0] clock_control_register_q;
    logic [DSCS_REG_W-1:0] eff_q;          // settings in force on the clock tree
    logic                  boot_done_q;
    logic [31:0]           prdata_q;
    logic                  hit;
    logic                  wr_acc;

    assign hit    = (paddr == DSCS_CKCTL_ADDR);
    assign wr_acc = psel && penable && pwrite && hit;

    // zero-wait slave; unmapped addresses answer with pslverr
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign prdata  = prdata_q;

    // software writes; fuse is caught one edge after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_control_register_q <= DSCS_CKCTL_RESET;
            boot_done_q              <= 1'b0;
        end else if (!boot_done_q) begin
            boot_done_q <= 1'b1;
            clock_control_register_q[DSCS_CPU_BIT] <= boot_double_speed_fuse;
        end else if (wr_acc) begin
            clock_control_register_q <= pwdata[DSCS_REG_W-1:0];
        end
    end

    // read data captured in the setup phase so it stands from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            prdata_q <= hit ? {24'h000000, clock_control_register_q} : 32'h00000000;
        end
    end

    // ************************************************************
    // divide-by-two stage and glitch-free switch
    // ************************************************************
    logic div_q;
    logic div_tick;                        // edge on which divided clock rises

    assign div_tick = !div_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 1'b0;
        end else begin
            div_q <= !div_q;
        end
    end

    // changes reach the tree only at the divided rising edge, so no
    // phase pulse is ever cut short mid-period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eff_q <= DSCS_CKCTL_RESET;
        end else if (div_tick) begin
            eff_q <= clock_control_register_q;
        end
    end

    assign standard_speed_mode = !eff_q[DSCS_CPU_BIT];

    // ************************************************************
    // phase and cycle enables, cpu at index 0
    // ************************************************************
    logic [NP:0] fast;
    logic [NP:0] phase;
    logic [NP:0] cycle;

    genvar g;
    generate
        for (g = 0; g <= NP; g++) begin : g_chan
            // cpu bit gates all selects; a set select keeps standard rate
            if (g == 0) begin : g_cpu
                assign fast[g] = eff_q[DSCS_CPU_BIT];
            end else begin : g_per
                assign fast[g] = eff_q[DSCS_CPU_BIT]
                               && !eff_q[DSCS_SEL_LSB+g-1];
            end
            assign phase[g] = fast[g] ? 1'b1 : div_tick;
            dscs_cycle_counter #(
                .PHASES (DSCS_PHASES_PER_CYCLE)
            ) u_cnt (
                .pclk     (pclk),
                .presetn  (presetn),
                .phase_en (phase[g]),
                .cycle_en (cycle[g])
            );
        end
    endgenerate

    assign core_phase_en    = phase[0];
    assign machine_cycle_en = cycle[0];
    assign periph_phase_en  = phase[NP:1];
    assign periph_cycle_en  = cycle[NP:1];

    // ************************************************************
    // checks
    // ************************************************************
    logic [4:0] gap_q;
    logic       stable_q;
    logic       cpu_change;
    logic       eff_change;
    localparam logic [4:0] GAP_STD  = 5'(DSCS_OSC_STD);
    localparam logic [4:0] GAP_FAST = 5'(DSCS_OSC_FAST);

    // a setting about to take hold; an interval it splits is never judged
    assign cpu_change = div_tick
                     && (eff_q[DSCS_CPU_BIT] != clock_control_register_q[DSCS_CPU_BIT]);
    assign eff_change = div_tick && (eff_q != clock_control_register_q);

    // oscillator periods between machine cycles; a cpu switch landing on
    // the pulse edge must win, or the mixed interval after it is judged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q    <= '0;
            stable_q <= 1'b0;
        end else begin
            gap_q <= machine_cycle_en ? 5'h01 : gap_q + 5'h01;
            if (cpu_change) begin
                stable_q <= 1'b0;
            end else if (machine_cycle_en) begin
                stable_q <= 1'b1;
            end
        end
    end

    property p_cycle_len;
        @(posedge pclk) disable iff (!presetn)
        (machine_cycle_en && stable_q)
            |-> gap_q == (eff_q[DSCS_CPU_BIT] ? GAP_FAST : GAP_STD);
    endproperty
    a_cycle_len: assert property (p_cycle_len) else $error("machine cycle length wrong");

    property p_reset_zero;
        @(posedge pclk) disable iff (!presetn)
        !boot_done_q |-> clock_control_register_q == DSCS_CKCTL_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("register not zero at reset");

    property p_boot_fuse;
        @(posedge pclk) disable iff (!presetn)
        (!boot_done_q && boot_double_speed_fuse) |=> ##[1:2] !standard_speed_mode;
    endproperty
    a_boot_fuse: assert property (p_boot_fuse)
        else $error("fuse did not start double speed");

    property p_boot_std;
        @(posedge pclk) disable iff (!presetn)
        (!boot_done_q && !boot_double_speed_fuse) |=> ##[1:2] standard_speed_mode;
    endproperty
    a_boot_std: assert property (p_boot_std) else $error("reset did not start standard");

    property p_switch_edge;
        @(posedge pclk) disable iff (!presetn)
        (eff_q != $past(eff_q)) |-> $past(div_q) == 1'b0;
    endproperty
    a_switch_edge: assert property (p_switch_edge)
        else $error("switch off divided edge");

    property p_std_divider;
        @(posedge pclk) disable iff (!presetn)
        standard_speed_mode |-> core_phase_en == div_tick && periph_phase_en == {NP{div_tick}};
    endproperty
    a_std_divider: assert property (p_std_divider) else $error("divider not in path");

    property p_sel_set;
        @(posedge pclk) disable iff (!presetn)
        (eff_q[DSCS_CPU_BIT] && eff_q[DSCS_SEL_LSB]) |-> periph_phase_en[0] == div_tick;
    endproperty
    a_sel_set: assert property (p_sel_set) else $error("set select still fast");

    property p_sel_clear;
        @(posedge pclk) disable iff (!presetn)
        (eff_q[DSCS_CPU_BIT] && !eff_q[DSCS_SEL_LSB]) |-> periph_phase_en[0] && core_phase_en;
    endproperty
    a_sel_clear: assert property (p_sel_clear) else $error("cleared select not fast");

    property p_sw_write;
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && boot_done_q) |=> clock_control_register_q == $past(pwdata[DSCS_REG_W-1:0])
            ##[1:2] eff_q == $past(clock_control_register_q);
    endproperty
    a_sw_write: assert property (p_sw_write) else $error("write not applied");

    property p_reset_out;
        @(posedge pclk) disable iff (!presetn)
        !boot_done_q |-> standard_speed_mode && prdata == 32'h00000000
                         && !machine_cycle_en && periph_cycle_en == '0;
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs busy after reset");

    property p_read_data;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite && hit && $past(boot_done_q))
            |-> prdata == {24'h000000, clock_control_register_q};
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("read data not the register");

    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !hit) |-> pslverr && (pwrite || prdata == 32'h00000000);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");

    property p_mapped_ok;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && hit) |-> pready && !pslverr;
    endproperty
    a_mapped_ok: assert property (p_mapped_ok)
        else $error("mapped access refused");

    property p_reg_quiet;
        @(posedge pclk) disable iff (!presetn)
        (boot_done_q && !wr_acc) |=> $stable(clock_control_register_q);
    endproperty
    a_reg_quiet: assert property (p_reg_quiet)
        else $error("register changed without a write");

    property p_core_fast;
        @(posedge pclk) disable iff (!presetn)
        !standard_speed_mode |-> core_phase_en;
    endproperty
    a_core_fast: assert property (p_core_fast)
        else $error("core not fast in double speed");

    property p_cpu_only;
        @(posedge pclk) disable iff (!presetn)
        (eff_q[DSCS_CPU_BIT] && &eff_q[DSCS_SEL_LSB+NP-1:DSCS_SEL_LSB])
            |-> core_phase_en && periph_phase_en == {NP{div_tick}};
    endproperty
    a_cpu_only: assert property (p_cpu_only)
        else $error("cpu bit alone sped a peripheral");

    property p_cycle_single;
        @(posedge pclk) disable iff (!presetn)
        machine_cycle_en |=> !machine_cycle_en;
    endproperty
    a_cycle_single: assert property (p_cycle_single)
        else $error("machine cycle pulse too long");

    // ************************************************************
    // per-peripheral cycle length
    // ************************************************************
    // each channel is judged only over an interval in which no setting
    // changed, since a select flip mid-interval mixes the two rates
    generate
        for (g = 1; g <= NP; g++) begin : g_pchk
            logic [4:0] pgap_q;
            logic       pstable_q;

            // oscillator periods since this channel's last cycle pulse
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pgap_q    <= '0;
                    pstable_q <= 1'b0;
                end else begin
                    pgap_q <= cycle[g] ? 5'h01 : pgap_q + 5'h01;
                    if (eff_change) begin
                        pstable_q <= 1'b0;
                    end else if (cycle[g]) begin
                        pstable_q <= 1'b1;
                    end
                end
            end

            property p_periph_len;
                @(posedge pclk) disable iff (!presetn)
                (cycle[g] && pstable_q)
                    |-> pgap_q == ((eff_q[DSCS_CPU_BIT] && !eff_q[DSCS_SEL_LSB+g-1])
                                   ? GAP_FAST : GAP_STD);
            endproperty
            a_periph_len: assert property (p_periph_len)
                else $error("peripheral cycle length wrong");
        end
    endgenerate
endmodule // dscs_clock_select

// ===== bench/dscs_clock_select_bench.sv
`timescale 1ns/100ps
module dscs_clock_select_bench
    import dscs_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, boot_double_speed_fuse;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, standard_speed_mode, core_phase_en, machine_cycle_en;
    logic [6:0]  periph_phase_en, periph_cycle_en;
    int          bad_count, total_checks, cycles, p;
    logic [7:0]  modes [5] = '{8'h00, 8'h01, 8'hff, 8'h55, 8'hfe};

    dscs_clock_select dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .boot_double_speed_fuse(boot_double_speed_fuse),
        .standard_speed_mode(standard_speed_mode), .core_phase_en(core_phase_en),
        .machine_cycle_en(machine_cycle_en), .periph_phase_en(periph_phase_en),
        .periph_cycle_en(periph_cycle_en));

    // ****************************************
    // clock, timeout and reporting
    // ****************************************
    always #12.5 pclk = ~pclk;
    // ceiling well above the fewer than 1500 cycles the tests need
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // ****************************************
    // apb access, held until pready is seen high
    // ****************************************
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic err);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    function automatic logic pick(input int s);
        if (s == 0) return machine_cycle_en;
        if (s == 1) return core_phase_en;
        if (s >= 9) return periph_phase_en[s-9];
        return periph_cycle_en[s-2];
    endfunction

    // period between two pulses, sampled at the falling edge where outputs are settled
    task automatic measure(input int s, output int per);
        int n;
        n = 0;
        do begin @(negedge pclk); n++; end while (pick(s) !== 1'b1 && n < 100);
        per = 0;
        do begin @(negedge pclk); per++; end while (pick(s) !== 1'b1 && per < 100);
    endtask

    task automatic do_reset(input logic fuse);
        presetn <= 1'b0; boot_double_speed_fuse <= fuse;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic e, exp_fast;
        pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        boot_double_speed_fuse = 0; bad_count = 0; total_checks = 0; cycles = 0;
        do_reset(1'b0);
        apb(1'b0, DSCS_CKCTL_ADDR, 0, rd, e);
        check(rd, 32'h0, "reset value");
        check(e, 1'b0, "mapped access error");
        check(pready, 1'b1, "zero wait answer");
        check(standard_speed_mode, 1'b1, "standard after reset");
        $display("test reset done");
        // every mode pattern: readback, cpu rate and each peripheral's rate
        foreach (modes[i]) begin
            apb(1'b1, DSCS_CKCTL_ADDR, {24'ha5a5a5, modes[i]}, rd, e);
            apb(1'b0, DSCS_CKCTL_ADDR, 0, rd, e);
            check(rd, {24'h0, modes[i]}, "readback");
            check(standard_speed_mode, !modes[i][0], "mode flag");
            repeat (30) @(posedge pclk);
            measure(1, p);
            check(p, modes[i][0] ? 1 : 2, "core phase period");
            measure(0, p);
            check(p, modes[i][0] ? DSCS_OSC_FAST : DSCS_OSC_STD, "machine cycle");
            for (int k = 0; k < 7; k++) begin
                exp_fast = modes[i][0] && !modes[i][k+1];
                measure(k + 2, p);
                check(p, exp_fast ? 6 : 12, "periph cycle");
                measure(k + 9, p);
                check(p, exp_fast ? 1 : 2, "periph phase");
            end
            $display("test mode %h done", modes[i]);
        end
        // unmapped address is refused and leaves the register alone
        apb(1'b1, DSCS_CKCTL_ADDR + 12'h004, 32'h0000_0001, rd, e);
        check(e, 1'b1, "unmapped write error");
        apb(1'b0, DSCS_CKCTL_ADDR + 12'h004, 0, rd, e);
        check(rd, 32'h0, "unmapped read");
        apb(1'b0, DSCS_CKCTL_ADDR, 0, rd, e);
        check(rd, 32'h0000_00fe, "register untouched");
        $display("test unmapped done");
        // fuse programmed: double speed straight out of reset
        do_reset(1'b1);
        apb(1'b0, DSCS_CKCTL_ADDR, 0, rd, e);
        check(rd, 32'h1, "fuse start value");
        check(standard_speed_mode, 1'b0, "fuse start mode");
        measure(0, p);
        check(p, DSCS_OSC_FAST, "fuse machine cycle");
        $display("test fuse done");
        stop_test();
    end
endmodule // dscs_clock_select_bench
